// >>> design/scr_pkg.sv
// Package: register map, field layout, codes and limits of the charger setpoint register bank
package scr_pkg;

  // Bus addressing
  localparam logic [6:0] SLAVE_ADDR   = 7'h09;
  // Register codes
  localparam logic [7:0] REG_CHG_CUR  = 8'h14;
  localparam logic [7:0] REG_CHG_VOLT = 8'h15;
  localparam logic [7:0] REG_IN_LIM   = 8'h3f;
  localparam logic [7:0] REG_MAKER    = 8'hfe;
  localparam logic [7:0] REG_PART     = 8'hff;
  // Reset values
  localparam logic [15:0] RST_CHG_CUR  = 16'h0000;
  localparam logic [15:0] RST_CHG_VOLT = 16'h0000;
  localparam logic [15:0] RST_IN_LIM   = 16'h0080;
  // Field positions
  localparam int VOLT_LSB = 4;
  localparam int VOLT_MSB = 14;
  localparam int CUR_LSB  = 7;
  localparam int CUR_MSB  = 12;
  // Enable thresholds
  localparam logic [15:0] CUR_EN_MIN  = 16'h007f;
  localparam logic [15:0] VOLT_EN_MIN = 16'h000f;
  // Voltage limits in mV and in DAC steps of 16 mV
  localparam logic [15:0] VOLT_MAX_MV   = 16'h4b00;
  localparam logic [10:0] VOLT_MAX_CODE = 11'h4b0;
  localparam logic [10:0] VOLT_MIN_CODE = 11'h040;
  // Current limits in mA and in DAC steps of 128 mA
  localparam logic [15:0] CUR_MAX_MA   = 16'h1f80;
  localparam logic [5:0]  CUR_MAX_CODE = 6'h3f;
  localparam logic [5:0]  CUR_FOLD     = 6'h01;
  // Input limit threshold in register steps of 2 mA (11004 mA)
  localparam logic [15:0] IN_MAX_MA    = 16'h157e;
  localparam logic [5:0]  IN_MAX_CODE  = 6'h2b;
  // Bit counter
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  // Bus transaction phases
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WLO, ST_WHI, ST_RLO, ST_RHI, ST_SKIP
  } scr_state_t;

  // Staged register write
  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic [15:0] data;
  } scr_wr_t;

  // Decoded setpoints toward the analog loop
  typedef struct packed {
    logic [10:0] voltage_dac_code;
    logic [5:0]  current_dac_code;
    logic [5:0]  input_limit_dac_code;
    logic        charge_enable;
  } scr_dac_t;

endpackage

// >>> design/scr_setpoint_regs.sv
// Module: serial slave front end, setpoint registers and DAC code decoding
`timescale 1ns/1ps
module scr_setpoint_regs #(
  parameter logic [15:0] MAKER_CODE = 16'h005a, // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0007  // Arbitrary value
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // Serial bus pins
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe,
  // Battery comparators on the battery sense node
  input  wire logic            batt_below_2v5,
  input  wire logic            batt_above_2v7,
  // Decoded setpoints
  output scr_pkg::scr_dac_t    dac_out,
  output logic                 foldback_active
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]  scl_sync_q;       // SCL synchroniser
  logic [1:0]  sda_sync_q;       // SDA synchroniser
  logic [1:0]  low_sync_q;       // Below 2.5V synchroniser
  logic [1:0]  high_sync_q;      // Above 2.7V synchroniser
  logic        scl_prev_q;       // SCL one cycle back
  logic        sda_prev_q;       // SDA one cycle back
  logic        armed_q;          // Start seen, its own clock fall not yet passed
  logic        scl_rise;         // Rising clock edge
  logic        scl_fall;         // Falling clock edge
  logic        bus_start;        // Start or repeated start
  logic        bus_stop;         // Stop condition
  scr_pkg::scr_state_t state_q;  // Transaction phase
  logic [3:0]  bit_cnt_q;        // Bit within byte, 8 is the ack slot
  logic [7:0]  rx_q;             // Received byte
  logic [7:0]  tx_q;             // Byte being sent
  logic        is_read_q;        // Direction from control byte
  logic        master_nak_q;     // Master answer after a read byte
  logic        sda_drv_q;        // Pull SDA low
  logic [7:0]  ptr_q;            // Selected register code
  logic [7:0]  lo_q;             // Low data byte of a write
  scr_pkg::scr_wr_t pend_q;      // Write waiting for the stop
  logic [15:0] chg_cur_q;        // Charge-current setpoint
  logic [15:0] chg_volt_q;       // Charge-voltage setpoint
  logic [15:0] in_lim_q;         // Input-current limit
  logic [15:0] rd_word;          // Word returned on reads
  logic        fold_q;           // Low-battery foldback
  logic [10:0] volt_code;        // Clamped voltage code
  logic [5:0]  cur_code;         // Clamped current code
  logic [5:0]  in_code;          // Clamped input limit code
  logic        chg_en;           // Charge enable condition

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two flops on every asynchronous input before use
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Bus lines idle high, comparators idle low
      scl_sync_q  <= 2'h3;
      sda_sync_q  <= 2'h3;
      low_sync_q  <= 2'h0;
      high_sync_q <= 2'h0;
    end else begin
      // Shift each pin in, one stage per cycle
      scl_sync_q  <= {scl_sync_q[0], scl_i};
      sda_sync_q  <= {sda_sync_q[0], sda_i};
      low_sync_q  <= {low_sync_q[0], batt_below_2v5};
      high_sync_q <= {high_sync_q[0], batt_above_2v7};
    end
  end

  // Delayed copies of the synchronised lines for edge detection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Idle level, so no false edge follows reset
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Bus events; only the second synchroniser stage is looked at
  always_comb begin
    scl_rise  = scl_sync_q[1] & ~scl_prev_q;
    scl_fall  = ~scl_sync_q[1] & scl_prev_q;
    bus_start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    bus_stop  = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data select

  // Word returned for the selected code; unmapped codes read zero
  always_comb begin
    case (ptr_q)
      scr_pkg::REG_CHG_CUR:  rd_word = chg_cur_q;
      scr_pkg::REG_CHG_VOLT: rd_word = chg_volt_q;
      scr_pkg::REG_IN_LIM:   rd_word = in_lim_q;
      scr_pkg::REG_MAKER:    rd_word = MAKER_CODE;
      scr_pkg::REG_PART:     rd_word = PART_CODE;
      default:               rd_word = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive shifter

  // Sample SDA on each rising clock edge of a data bit, MSB first
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_q         <= 8'h00;
      master_nak_q <= 1'b1;
    end else if (scl_rise) begin
      // The ack slot answer is kept out of the data byte
      if (bit_cnt_q != scr_pkg::BIT_ACK) begin
        rx_q <= {rx_q[6:0], sda_sync_q[1]};
      end else begin
        master_nak_q <= sda_sync_q[1];       // Ack slot answer
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transaction state machine

  // Phase, bit count, SDA drive and transmit byte; advanced on falling edges.
  // The device only answers: it drives SDA low for acks and read data, never SCL.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q   <= scr_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      sda_drv_q <= 1'b0;
      tx_q      <= 8'h00;
      is_read_q <= 1'b0;
      ptr_q     <= 8'h00;
      lo_q      <= 8'h00;
      armed_q   <= 1'b0;
    end else if (bus_start) begin
      // Start or repeated start: expect a control byte
      state_q   <= scr_pkg::ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_drv_q <= 1'b0;
      armed_q   <= 1'b1;
    end else if (bus_stop) begin
      // Stop: release the bus
      state_q   <= scr_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      sda_drv_q <= 1'b0;
      armed_q   <= 1'b0;
    end else if (scl_fall && armed_q) begin
      // The fall that closes a start carries no bit; counting it would end the byte early
      armed_q   <= 1'b0;
    end else if (scl_fall && state_q != scr_pkg::ST_IDLE && state_q != scr_pkg::ST_SKIP) begin
      if (bit_cnt_q == scr_pkg::BIT_LAST) begin
        // Eighth bit done: decide the ack slot
        bit_cnt_q <= scr_pkg::BIT_ACK;
        case (state_q)
          scr_pkg::ST_ADDR: begin
            // Own address: ack it and keep the direction bit
            if (rx_q[7:1] == scr_pkg::SLAVE_ADDR) begin
              sda_drv_q <= 1'b1;
              is_read_q <= rx_q[0];
            end else begin
              sda_drv_q <= 1'b0;
              state_q   <= scr_pkg::ST_SKIP;
            end
          end
          scr_pkg::ST_CMD: begin
            // Register code byte is always acked
            sda_drv_q <= 1'b1;
            ptr_q     <= rx_q;
          end
          scr_pkg::ST_WLO: begin
            sda_drv_q <= 1'b1;
            // Low byte waits here for its high byte
            lo_q      <= rx_q;
          end
          scr_pkg::ST_WHI: begin
            // High byte acked; the staged word is captured when this ack slot ends
            sda_drv_q <= 1'b1;
          end
          default: begin
            sda_drv_q <= 1'b0;                // Master answers read bytes
          end
        endcase
      end else if (bit_cnt_q == scr_pkg::BIT_ACK) begin
        // Ack slot done: move to the next byte
        bit_cnt_q <= 4'h0;
        sda_drv_q <= 1'b0;
        case (state_q)
          scr_pkg::ST_ADDR: begin
            // Read: put the low byte MSB on the line at once
            if (is_read_q) begin
              state_q   <= scr_pkg::ST_RLO;
              tx_q      <= rd_word[7:0];
              sda_drv_q <= ~rd_word[7];
            end else begin
              state_q <= scr_pkg::ST_CMD;
            end
          end
          scr_pkg::ST_CMD: begin
            state_q <= scr_pkg::ST_WLO;
          end
          scr_pkg::ST_WLO: begin
            state_q <= scr_pkg::ST_WHI;
          end
          scr_pkg::ST_RLO: begin
            // Master ack asks for the high byte; a refusal ends the read
            if (!master_nak_q) begin
              state_q   <= scr_pkg::ST_RHI;
              tx_q      <= rd_word[15:8];
              sda_drv_q <= ~rd_word[15];
            end else begin
              state_q <= scr_pkg::ST_SKIP;
            end
          end
          default: begin
            state_q <= scr_pkg::ST_SKIP;      // One word per transaction
          end
        endcase
      end else begin
        // Next data bit
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (state_q == scr_pkg::ST_RLO || state_q == scr_pkg::ST_RHI) begin
          tx_q      <= {tx_q[6:0], 1'b0};
          sda_drv_q <= ~tx_q[6];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Staged write

  // Capture a full word once the high byte is acked; a start discards it
  // Only a word whose high byte was acked can reach the stop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else if (bus_start || bus_stop) begin
      pend_q <= '0;
    end else if (scl_fall && state_q == scr_pkg::ST_WHI && bit_cnt_q == scr_pkg::BIT_ACK) begin
      pend_q.valid <= 1'b1;
      pend_q.code  <= ptr_q;
      pend_q.data  <= {rx_q, lo_q};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Setpoint registers

  // Committed only at the stop that ends a complete write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chg_cur_q  <= scr_pkg::RST_CHG_CUR;
      chg_volt_q <= scr_pkg::RST_CHG_VOLT;
      in_lim_q   <= scr_pkg::RST_IN_LIM;
    end else if (bus_stop && pend_q.valid) begin
      // The code latched with the word picks the target
      case (pend_q.code)
        scr_pkg::REG_CHG_CUR:  chg_cur_q  <= pend_q.data;
        scr_pkg::REG_CHG_VOLT: chg_volt_q <= pend_q.data;
        scr_pkg::REG_IN_LIM:   in_lim_q   <= pend_q.data;
        default: begin
          // Identification and unmapped codes ignore writes
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Low-battery foldback

  // Hysteresis: set below 2.5V, cleared only above 2.7V
  // Below wins when both comparators read high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fold_q <= 1'b0;
    end else if (low_sync_q[1]) begin
      fold_q <= 1'b1;
    end else if (high_sync_q[1]) begin
      fold_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DAC code decoding

  // Clamp and scale the stored setpoints
  always_comb begin
    // Voltage in mV, 16 mV per code step, bit 15 ignored
    volt_code = chg_volt_q[scr_pkg::VOLT_MSB:scr_pkg::VOLT_LSB];
    if (volt_code > scr_pkg::VOLT_MAX_CODE) begin
      volt_code = scr_pkg::VOLT_MAX_CODE;
    end else if (volt_code < scr_pkg::VOLT_MIN_CODE) begin
      volt_code = 11'h000;
    end
    // Current in mA, 128 mA per code step
    // Any of bits 15 to 13 set puts the value past the clamp
    if (chg_cur_q > scr_pkg::CUR_MAX_MA) begin
      cur_code = scr_pkg::CUR_MAX_CODE;
    end else begin
      cur_code = chg_cur_q[scr_pkg::CUR_MSB:scr_pkg::CUR_LSB];
    end
    // Input limit, 256 mA per code step
    // Register counts 2 mA, so the clamp threshold is in those steps
    if (in_lim_q > scr_pkg::IN_MAX_MA) begin
      in_code = scr_pkg::IN_MAX_CODE;
    end else begin
      in_code = in_lim_q[scr_pkg::CUR_MSB:scr_pkg::CUR_LSB];
    end
    // Charging needs both setpoints valid
    chg_en = (chg_cur_q > scr_pkg::CUR_EN_MIN) && (chg_volt_q > scr_pkg::VOLT_EN_MIN)
             && (volt_code != 11'h000);
  end

  // Registered DAC outputs
  // Foldback swaps only the applied code; the register is left alone
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dac_out         <= '0;
      foldback_active <= 1'b0;
    end else begin
      dac_out.voltage_dac_code     <= volt_code;
      dac_out.current_dac_code     <= fold_q ? scr_pkg::CUR_FOLD : cur_code;
      dac_out.input_limit_dac_code <= in_code;
      dac_out.charge_enable        <= chg_en;
      foldback_active              <= fold_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive

  // Open-drain SDA: enable high means pull low
  // Never driven high: the pull-up makes the released level
  always_comb begin
    sda_o  = 1'b0;
    sda_oe = sda_drv_q;
  end

endmodule

// >>> tb/scr_setpoint_regs_asserts.sv
// Checker: port relations of the charger setpoint register bank
`timescale 1ns/1ps
module scr_setpoint_regs_asserts (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_n,
  // Serial bus pins
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe,
  // Battery comparators
  input wire logic              batt_below_2v5,
  input wire logic              batt_above_2v7,
  // Decoded setpoints
  input wire scr_pkg::scr_dac_t dac_out,
  input wire logic              foldback_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Slave drive moves only while the clock is low, so it never forms a start
  property p_no_start; $changed(sda_oe) |-> !scl_i; endproperty
  a_no_start: assert property (p_no_start) else $error("sda drive moved with scl high");
  // Enable needs both setpoints live
  property p_enable; dac_out.charge_enable |-> dac_out.voltage_dac_code != 0 && dac_out.current_dac_code != 0;
  endproperty
  a_enable: assert property (p_enable) else $error("charge enabled with zero code");
  // Voltage code is zero or inside the clamp window
  property p_volt_range; dac_out.voltage_dac_code <= scr_pkg::VOLT_MAX_CODE &&
    (dac_out.voltage_dac_code == 0 || dac_out.voltage_dac_code >= scr_pkg::VOLT_MIN_CODE); endproperty
  a_volt_range: assert property (p_volt_range) else $error("voltage code out of range");
  // Input limit code never beyond its clamp
  property p_in_limit; dac_out.input_limit_dac_code <= scr_pkg::IN_MAX_CODE; endproperty
  a_in_limit: assert property (p_in_limit) else $error("input limit code too large");
  // Settled foldback forces the trickle code
  property p_fold_code; foldback_active && $past(foldback_active) |-> dac_out.current_dac_code == scr_pkg::CUR_FOLD;
  endproperty
  a_fold_code: assert property (p_fold_code) else $error("foldback code wrong");
  // Low battery raises foldback within the synchroniser delay
  property p_fold_set; $rose(batt_below_2v5) |-> ##[1:6] foldback_active; endproperty
  a_fold_set: assert property (p_fold_set) else $error("foldback not raised");
  // Recovered battery drops foldback
  property p_fold_clear; (batt_above_2v7 && !batt_below_2v5) [*6] |-> !foldback_active; endproperty
  a_fold_clear: assert property (p_fold_clear) else $error("foldback not cleared");
  // Voltage code moves only after a stop, which leaves the clock high
  property p_dac_quiet; $changed(dac_out.voltage_dac_code) |-> scl_i; endproperty
  a_dac_quiet: assert property (p_dac_quiet) else $error("voltage code moved mid frame");
  // Leaving reset gives zero setpoints and the default input limit
  property p_reset_val; $rose(rst_n) |-> ##[0:2] dac_out == 24'h000002; endproperty
  a_reset_val: assert property (p_reset_val) else $error("wrong outputs after reset");
endmodule
bind scr_setpoint_regs scr_setpoint_regs_asserts i_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .batt_below_2v5(batt_below_2v5), .batt_above_2v7(batt_above_2v7),
  .dac_out(dac_out), .foldback_active(foldback_active));

// >>> tb/scr_smbus_host.sv
// Bus host model: drives the clock and pulls the open-drain data line low
`timescale 1ns/1ps
module scr_smbus_host (
  // Bench clock
  input  wire logic ref_clk,
  // Bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Idle bus, both lines released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Wait core cycles, then step off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Start or repeated start: data falls with clock high
  task automatic start();
    sda_low = 1'b0;
    wt(7);
    scl = 1'b1;
    wt(10);
    sda_low = 1'b1;
    wt(10);
    scl = 1'b0;
    wt(3);
  endtask
  // Stop: data rises with clock high, clock stays high
  task automatic stop();
    sda_low = 1'b1;
    wt(7);
    scl = 1'b1;
    wt(10);
    sda_low = 1'b0;
    wt(10);
  endtask
  // One clock pulse, data sampled at the end of the high phase
  task automatic pulse(output logic s);
    wt(7);
    scl = 1'b1;
    wt(10);
    s = sda;
    scl = 1'b0;
    wt(3);
  endtask
  // Send eight bits MSB first, return the ack slot (0 = acked)
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse(s);
    end
    sda_low = 1'b0;
    pulse(ack);
  endtask
  // Receive eight bits MSB first, then ack or refuse
  task automatic rx(input logic nak, output logic [7:0] b);
    logic s;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_low = ~nak;
    pulse(s);
    sda_low = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Write-Word: address, code, low byte, high byte, stop
  task automatic write_word(input logic [7:0] code, input logic [15:0] d, output logic [3:0] a);
    start();
    tx(8'h12, a[3]);
    tx(code, a[2]);
    tx(d[7:0], a[1]);
    tx(d[15:8], a[0]);
    stop();
  endtask
  // Read-Word: select code, stop, then fetch low and high bytes
  task automatic read_word(input logic [7:0] code, output logic [15:0] d, output logic [3:0] a);
    start();
    tx(8'h12, a[3]);
    tx(code, a[2]);
    stop();
    start();
    tx(8'h13, a[1]);
    rx(1'b0, d[7:0]);
    rx(1'b1, d[15:8]);
    stop();
    a[0] = 1'b0;
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the charger setpoint register bank
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] MAKER = 16'h00c3; // Arbitrary value
  localparam logic [15:0] PART  = 16'h0011; // Arbitrary value
  // Clock, reset and pins
  logic              ref_clk;
  logic              rst_n;
  logic              scl;
  logic              host_low;
  logic              sda_o;
  logic              sda_oe;
  logic              batt_below_2v5;
  logic              batt_above_2v7;
  scr_pkg::scr_dac_t dac_out;
  logic              foldback_active;
  wire logic         sda;
  // Bookkeeping and reset table
  int                failures = 0;
  int                total_checks = 0;
  logic [15:0]       rd;
  logic [3:0]        acks;
  logic              ack;
  logic [7:0]        codes [5] = '{8'h14, 8'h15, 8'h3f, 8'hfe, 8'hff};
  logic [15:0]       vals [5] = '{16'h0000, 16'h0000, 16'h0080, MAKER, PART};
  // Pulled-up data wire
  assign sda = ~(host_low | (sda_oe & ~sda_o));
  scr_setpoint_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .batt_below_2v5(batt_below_2v5), .batt_above_2v7(batt_above_2v7),
    .dac_out(dac_out), .foldback_active(foldback_active));
  scr_smbus_host i_host (.ref_clk(ref_clk), .scl(scl), .sda_low(host_low), .sda(sda));
  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare register-sized and setpoint-sized values
  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_dac(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Report and end the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hold reset for five cycles, then let the synchronisers flush
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  // Write a word, check outputs, read it back
  task automatic wc(input logic [7:0] c, input logic [15:0] d, input logic [15:0] rb, input logic [23:0] e);
    i_host.write_word(c, d, acks);
    chk_reg("write acks", 16'h0000, {12'h000, acks});
    chk_dac("dac", e, dac_out);
    i_host.read_word(c, rd, acks);
    chk_reg("read acks", 16'h0000, {12'h000, acks});
    chk_reg("readback", rb, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n          = 1'b0;
    batt_below_2v5 = 1'b0;
    batt_above_2v7 = 1'b0;
    do_reset();
    chk_dac("reset dac", 24'h000002, dac_out);
    chk_reg("sda_o level", 16'h0000, {15'h0000, sda_o});
    for (int k = 0; k < 5; k++) begin
      i_host.read_word(codes[k], rd, acks);
      chk_reg("reset read", vals[k], rd);
    end
    wc(8'h14, 16'h0080, 16'h0080, 24'h000082);
    wc(8'h15, 16'h41a0, 16'h41a0, 24'h834083);
    wc(8'h15, 16'hffff, 16'hffff, 24'h960083);
    wc(8'h15, 16'h03f0, 16'h03f0, 24'h000082);
    wc(8'h15, 16'h0400, 16'h0400, 24'h080083);
    wc(8'h14, 16'hffff, 16'hffff, 24'h081f83);
    wc(8'h14, 16'h007f, 16'h007f, 24'h080002);
    wc(8'h3f, 16'hffff, 16'hffff, 24'h080056);
    wc(8'h3f, 16'h1fff, 16'h1fff, 24'h080056);
    wc(8'h14, 16'h0100, 16'h0100, 24'h080157);
    wc(8'h15, 16'h0000, 16'h0000, 24'h000156);
    wc(8'hfe, 16'h1234, MAKER, 24'h000156);
    wc(8'h15, 16'h0400, 16'h0400, 24'h080157);
    // Full word sent, then a repeated start instead of a stop
    i_host.start();
    i_host.tx(8'h12, ack);
    i_host.tx(8'h14, ack);
    i_host.tx(8'hff, ack);
    i_host.tx(8'h0f, ack);
    chk_reg("high byte ack", 16'h0000, {15'h0000, ack});
    chk_dac("dac before stop", 24'h080157, dac_out);
    i_host.start();
    i_host.stop();
    i_host.read_word(8'h14, rd, acks);
    chk_reg("read after abort", 16'h0100, rd);
    // Foreign address is not acknowledged
    i_host.start();
    i_host.tx(8'h14, ack);
    chk_reg("foreign address", 16'h0001, {15'h0000, ack});
    i_host.stop();
    // Low battery foldback and recovery
    batt_below_2v5 = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk_reg("foldback flag", 16'h0001, {15'h0000, foldback_active});
    chk_dac("foldback dac", 24'h0800d7, dac_out);
    i_host.read_word(8'h14, rd, acks);
    chk_reg("folded readback", 16'h0100, rd);
    batt_below_2v5 = 1'b0;
    batt_above_2v7 = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk_reg("recovered flag", 16'h0000, {15'h0000, foldback_active});
    chk_dac("recovered dac", 24'h080157, dac_out);
    // Second reset in mid-run
    do_reset();
    chk_dac("second reset dac", 24'h000002, dac_out);
    i_host.read_word(8'h14, rd, acks);
    chk_reg("second reset read", 16'h0000, rd);
    test_done();
  end
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    failures++;
    $display("wrong value watchdog expected finish seen timeout");
    test_done();
  end
endmodule
